// file: verilog/status_report_pkg.sv
/*
  constants and carrier types for the command-mode input data bank.
  assumes one 50 mhz clock and a synchronous active-low reset.
*/
package status_report_pkg;

  // word indices of the input data block
  localparam logic [3:0] W_MOTION_STATUS = 4'h0;
  localparam logic [3:0] W_DRIVE_STATUS = 4'h1;
  localparam logic [3:0] W_MOTOR_UPPER = 4'h2;
  localparam logic [3:0] W_MOTOR_LOWER = 4'h3;
  localparam logic [3:0] W_ENCODER_UPPER = 4'h4;
  localparam logic [3:0] W_ENCODER_LOWER = 4'h5;
  localparam logic [3:0] W_CAPTURED_UPPER = 4'h6;
  localparam logic [3:0] W_CAPTURED_LOWER = 4'h7;
  localparam logic [3:0] W_CURRENT = 4'h8;
  localparam logic [3:0] W_JERK = 4'h9;

  // reserved positions in the drive status word
  localparam int B_RSVD_HI = 12;
  localparam int B_RSVD_LO = 8;

  // values after reset
  localparam logic CFG_ERR_RST = 1'b1;
  localparam logic POS_INV_RST = 1'b1;
  localparam logic [15:0] CURRENT_RST = 16'h000a;

  // accepted current range, amps times ten
  localparam logic [15:0] CURRENT_MIN = 16'h000a;
  localparam logic [15:0] CURRENT_MAX = 16'h003c;

  // gearing ratio range
  localparam logic [15:0] GEAR_MIN = 16'h0001;
  localparam logic [15:0] GEAR_MAX = 16'h00ff;

  // split decimal base
  localparam logic signed [31:0] DEC_BASE = 32'sd1000;

  // heartbeat timing
  localparam int CLK_HZ = 50000000;
  localparam int HEARTBEAT_MS = 500;
  localparam int HEARTBEAT_CYCLES = HEARTBEAT_MS * (CLK_HZ / 1000);
  localparam int HB_CNT_W = 25;

  typedef struct packed {
    logic move_done;
    logic move_cmd;
    logic preset;
    logic homing_done;
    logic jog_start;
    logic jog_reverse;
    logic cmd_invalid;
    logic jog_reg_range_err;
    logic error_reset;
    logic fault_clear;
    logic stop_event;
    logic stall;
    logic net_reconnect;
    logic jog_change_bad;
    logic cfg_write;
    logic cfg_valid;
    logic current_write;
  } event_in_t;

  typedef struct packed {
    logic config_mode;
    logic internal_fault;
    logic stall_detect_en;
    logic binary_format;
    logic upper_first;
    logic move_active;
    logic homing_active;
    logic homing_reverse;
    logic accelerating;
    logic decelerating;
    logic turning_forward;
    logic turning_reverse;
    logic hold_state;
    logic assy_mode;
    logic segment_slot_ready;
    logic driver_enable_req;
    logic motor_idle;
    logic idle_to_zero;
    logic gearing_active;
    logic overtemp;
    logic short_circuit;
    logic interlock_missing;
  } level_in_t;

  typedef struct packed {
    logic estop;
    logic limit_fwd;
    logic limit_rev;
    logic output_one;
  } pin_in_t;

endpackage : status_report_pkg

// file: verilog/motion_status_reporting.sv
/*
  command-mode input data bank: ten 16-bit words read by word index,
  status flags, position formatting, current acceptance and heartbeat.
  assumes events and levels come from logic on mclk, pins are asynchronous.
*/
module motion_status_reporting
  import status_report_pkg::*;
#(
  parameter int HB_CYCLES = HEARTBEAT_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data_r,
  output logic rd_valid_r,
  input wire event_in_t ev,
  input wire level_in_t lv,
  input wire pin_in_t pins,
  input wire logic signed [31:0] motor_pos,
  input wire logic signed [31:0] encoder_pos,
  input wire logic signed [31:0] captured_pos,
  input wire logic [15:0] current_value,
  input wire logic [15:0] jerk_value,
  input wire logic [15:0] gear_num,
  input wire logic [15:0] gear_den,
  output logic [15:0] current_accepted_r,
  output logic cmd_permit_r,
  output logic abs_move_permit_r,
  output logic power_stage_on_r
);

  // floor split into upper thousands and lower 0..999; overflow just wraps
  function automatic logic [31:0] split_decimal(input logic signed [31:0] pos);
    logic signed [31:0] q;
    logic signed [31:0] r;
    q = pos / DEC_BASE;
    r = pos % DEC_BASE;
    if (r < 0) begin
      q = q - 32'sd1;
      r = r + DEC_BASE;
    end
    return {q[15:0], r[15:0]};
  endfunction : split_decimal

  // returns {word at upper index, word at lower index}
  function automatic logic [31:0] format_pos(input logic signed [31:0] pos,
                                             input logic binary,
                                             input logic upper_first);
    logic [31:0] v;
    v = binary ? pos : split_decimal(pos);
    if (binary && !upper_first) begin
      return {v[15:0], v[31:16]};
    end
    return v;
  endfunction : format_pos

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  // pin synchronisers
  pin_in_t pin_s1_r;
  pin_in_t pin_s2_r;
  pin_in_t pin_d_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  logic estop_rise;
  logic limit_any;
  logic limit_release;
  logic limit_in_move;
  logic jog_into_limit;
  logic homing_far_limit;
  logic gear_bad;
  logic cur_ok;

  assign estop_rise = pin_s2_r.estop && !pin_d_r.estop;
  assign limit_any = pin_s2_r.limit_fwd || pin_s2_r.limit_rev;
  assign limit_release = (pin_d_r.limit_fwd && !pin_s2_r.limit_fwd)
                      || (pin_d_r.limit_rev && !pin_s2_r.limit_rev);
  assign limit_in_move = lv.move_active && !lv.homing_active && limit_any;
  assign jog_into_limit = ev.jog_start
                       && (ev.jog_reverse ? pin_s2_r.limit_rev : pin_s2_r.limit_fwd);
  assign homing_far_limit = lv.homing_active
                         && (lv.homing_reverse ? pin_s2_r.limit_fwd : pin_s2_r.limit_rev);
  assign gear_bad = lv.gearing_active
                 && !(in_range(gear_num, GEAR_MIN, GEAR_MAX)
                      && in_range(gear_den, GEAR_MIN, GEAR_MAX));
  assign cur_ok = in_range(current_value, CURRENT_MIN, CURRENT_MAX);

  // sticky flags; a set in the same cycle as its clear wins
  logic config_err_r;
  logic cmd_err_r;
  logic input_err_r;
  logic pos_inv_r;
  logic move_cmp_r;
  logic reference_reached_r;
  logic stall_seen_r;
  logic limit_cond_r;
  logic jog_bad_r;
  logic drv_fault_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      config_err_r <= CFG_ERR_RST;
    end else if (ev.cfg_write) begin
      config_err_r <= !ev.cfg_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_err_r <= 1'b0;
    end else if (ev.cmd_invalid || ev.jog_reg_range_err) begin
      cmd_err_r <= 1'b1;
    end else if (ev.error_reset) begin
      cmd_err_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      input_err_r <= 1'b0;
    end else if (estop_rise || limit_in_move || jog_into_limit || homing_far_limit) begin
      input_err_r <= 1'b1;
    end else if (ev.error_reset) begin
      input_err_r <= 1'b0;
    end
  end

  logic pos_inv_set;
  assign pos_inv_set = ev.cfg_write || ev.net_reconnect || ev.stop_event
                    || ev.stall || (lv.move_active && limit_any);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pos_inv_r <= POS_INV_RST;
    end else if (pos_inv_set) begin
      pos_inv_r <= 1'b1;
    end else if (ev.preset || ev.homing_done) begin
      pos_inv_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      move_cmp_r <= 1'b0;
    end else if (ev.move_done || ev.jog_reg_range_err) begin
      move_cmp_r <= 1'b1;
    end else if (ev.move_cmd || ev.preset || ev.error_reset) begin
      move_cmp_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reference_reached_r <= 1'b0;
    end else if (ev.homing_done) begin
      reference_reached_r <= 1'b1;
    end else if (ev.move_cmd || ev.preset || pos_inv_set) begin
      reference_reached_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stall_seen_r <= 1'b0;
    end else if (ev.stall) begin
      stall_seen_r <= 1'b1;
    end else if (ev.error_reset) begin
      stall_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      limit_cond_r <= 1'b0;
    end else if (lv.move_active && limit_any) begin
      limit_cond_r <= 1'b1;
    end else if (limit_release || ev.error_reset) begin
      limit_cond_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      jog_bad_r <= 1'b0;
    end else if (ev.jog_change_bad || gear_bad) begin
      jog_bad_r <= 1'b1;
    end else if (ev.error_reset) begin
      jog_bad_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      drv_fault_r <= 1'b0;
    end else if (lv.driver_enable_req
                 && (lv.overtemp || lv.short_circuit || lv.interlock_missing)) begin
      drv_fault_r <= 1'b1;
    end else if (ev.fault_clear) begin
      drv_fault_r <= 1'b0;
    end
  end

  // last accepted motor current
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      current_accepted_r <= CURRENT_RST;
    end else if (ev.current_write && cur_ok) begin
      current_accepted_r <= current_value;
    end
  end

  // permits steering the rest of the device
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_permit_r <= 1'b0;
      abs_move_permit_r <= 1'b0;
      power_stage_on_r <= 1'b0;
    end else begin
      cmd_permit_r <= !config_err_r;
      abs_move_permit_r <= !pos_inv_r && !pos_inv_set;
      power_stage_on_r <= lv.driver_enable_req && !drv_fault_r && !config_err_r
                       && !(lv.motor_idle && lv.idle_to_zero);
    end
  end

  // free-running heartbeat
  logic [HB_CNT_W-1:0] hb_cnt_r;
  logic hb_r;
  logic hb_wrap;
  assign hb_wrap = hb_cnt_r == HB_CNT_W'(HB_CYCLES - 1);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hb_cnt_r <= '0;
      hb_r <= 1'b0;
    end else begin
      hb_cnt_r <= hb_wrap ? '0 : hb_cnt_r + 1'b1;
      if (hb_wrap) begin
        hb_r <= !hb_r;
      end
    end
  end

  // formatted positions
  logic [31:0] motor_fmt_r;
  logic [31:0] encoder_fmt_r;
  logic [31:0] captured_fmt_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      motor_fmt_r <= '0;
      encoder_fmt_r <= '0;
      captured_fmt_r <= '0;
    end else begin
      motor_fmt_r <= format_pos(motor_pos, lv.binary_format, lv.upper_first);
      encoder_fmt_r <= format_pos(encoder_pos, lv.binary_format, lv.upper_first);
      captured_fmt_r <= format_pos(captured_pos, lv.binary_format, lv.upper_first);
    end
  end

  // status words
  logic [15:0] motion_status_word;
  logic [15:0] drive_status_word;

  always_comb begin
    motion_status_word = {
      lv.config_mode,
      !lv.internal_fault,
      lv.config_mode ? lv.stall_detect_en : config_err_r,
      cmd_err_r,
      input_err_r,
      pos_inv_r,
      lv.segment_slot_ready,
      lv.assy_mode,
      move_cmp_r,
      lv.decelerating,
      lv.accelerating && !lv.decelerating,
      reference_reached_r,
      !(lv.turning_forward || lv.turning_reverse),
      lv.hold_state,
      lv.turning_reverse,
      lv.turning_forward
    };
    drive_status_word = '0;
    drive_status_word[15] = power_stage_on_r;
    drive_status_word[14] = stall_seen_r;
    drive_status_word[13] = pin_s2_r.output_one;
    drive_status_word[11] = hb_r && !lv.config_mode;
    drive_status_word[10] = limit_cond_r;
    drive_status_word[9] = jog_bad_r;
    drive_status_word[7] = drv_fault_r;
  end

  // word read port; unmapped index reads zero
  logic [15:0] rd_word;
  always_comb begin
    case (rd_addr)
      W_MOTION_STATUS: rd_word = motion_status_word;
      W_DRIVE_STATUS: rd_word = drive_status_word;
      W_MOTOR_UPPER: rd_word = motor_fmt_r[31:16];
      W_MOTOR_LOWER: rd_word = motor_fmt_r[15:0];
      W_ENCODER_UPPER: rd_word = encoder_fmt_r[31:16];
      W_ENCODER_LOWER: rd_word = encoder_fmt_r[15:0];
      W_CAPTURED_UPPER: rd_word = captured_fmt_r[31:16];
      W_CAPTURED_LOWER: rd_word = captured_fmt_r[15:0];
      W_CURRENT: rd_word = current_accepted_r;
      W_JERK: rd_word = jerk_value;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_en ? rd_word : '0;
      rd_valid_r <= rd_en;
    end
  end

  // checks
  cfg_err_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    ev.cfg_write && ev.cfg_valid |=> !config_err_r ##1 cmd_permit_r)
    else $error("valid configuration did not clear the error");
  cmd_err_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd_err_r && !ev.error_reset |=> cmd_err_r)
    else $error("command error dropped without error reset");
  range_err_pair_a: assert property (@(posedge mclk) disable iff (!resetn)
    ev.jog_reg_range_err |=> move_cmp_r && cmd_err_r)
    else $error("range error did not set both flags");
  current_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    ev.current_write && !cur_ok && !cmd_err_r && !ev.cmd_invalid && !ev.jog_reg_range_err
      |=> $stable(current_accepted_r) && !cmd_err_r)
    else $error("out-of-range current changed the setting");
  stall_abs_block_a: assert property (@(posedge mclk) disable iff (!resetn)
    ev.stall |=> !abs_move_permit_r && pos_inv_r)
    else $error("absolute moves still allowed after stall");
  heartbeat_flip_a: assert property (@(posedge mclk) disable iff (!resetn)
    hb_wrap |=> hb_r != $past(hb_r))
    else $error("heartbeat did not toggle at wrap");
  fault_power_a: assert property (@(posedge mclk) disable iff (!resetn)
    drv_fault_r |=> !power_stage_on_r)
    else $error("power stage on during driver fault");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en && rd_addr == W_DRIVE_STATUS |=> rd_valid_r && !rd_data_r[B_RSVD_HI]
      && !rd_data_r[B_RSVD_LO])
    else $error("reserved status bits read non-zero");
  lower_digits_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en && rd_addr == W_MOTOR_LOWER && !$past(lv.binary_format)
      |=> rd_data_r < 16'h03e8)
    else $error("decimal lower word above 999");
  mode_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en && rd_addr == W_MOTION_STATUS |=> rd_data_r[15] == $past(lv.config_mode))
    else $error("mode bit does not follow configuration mode");

endmodule : motion_status_reporting

// file: verification/host_reader.sv
/*
  network host model: sweeps word indices 0..15 back to back on a go pulse
  and keeps the returned words. assumes the read port answers one cycle late.
*/
module host_reader (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic go,
  output logic rd_en,
  output logic [3:0] rd_addr,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r,
  output logic [15:0] words [16],
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] addr_q;

  // request side, one word per cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_en <= 1'b0;
      rd_addr <= 4'h0;
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      rd_en <= 1'b1;
      rd_addr <= 4'h0;
    end else if (rd_en) begin
      rd_en <= (rd_addr != 4'hf);
      rd_addr <= rd_addr + 4'h1;
    end else begin
      // released index keeps moving
      rd_addr <= ~rd_addr;
      if (rd_valid_r && addr_q == 4'hf) begin
        busy <= 1'b0;
      end
    end
  end

  // answer side
  always_ff @(posedge mclk) begin
    addr_q <= rd_addr;
    if (rd_valid_r) begin
      words[addr_q] <= rd_data_r;
    end
  end
endmodule : host_reader

// file: verification/testbench.sv
/*
  self-checking bench for the input data bank, reads through host_reader.
  assumes the heartbeat parameter shortened to 8 cycles.
*/
module testbench
  import status_report_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, resetn, go, busy, rd_en, rd_valid_r, cmd_permit_r, abs_move_permit_r;
  logic power_stage_on_r;
  logic [3:0] rd_addr;
  logic [15:0] rd_data_r, current_accepted_r, current_value, jerk_value, gear_num, gear_den;
  logic [15:0] w [16];
  logic [31:0] e;
  logic [6:0] r;
  logic signed [31:0] motor_pos, encoder_pos, captured_pos, p;
  event_in_t ev;
  level_in_t lv;
  pin_in_t pins;
  int n_fail, n_tests, k, i, j, hb0, hb1;
  logic [15:0] cv [4] = '{16'h003c, 16'h003d, 16'h0009, 16'h000a};
  logic [15:0] ce [4] = '{16'h003c, 16'h003c, 16'h003c, 16'h000a};

  motion_status_reporting #(.HB_CYCLES(8)) motion_status_reporting_i (
    .mclk(mclk), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .ev(ev), .lv(lv), .pins(pins), .motor_pos(motor_pos),
    .encoder_pos(encoder_pos), .captured_pos(captured_pos), .current_value(current_value),
    .jerk_value(jerk_value), .gear_num(gear_num), .gear_den(gear_den),
    .current_accepted_r(current_accepted_r), .cmd_permit_r(cmd_permit_r),
    .abs_move_permit_r(abs_move_permit_r), .power_stage_on_r(power_stage_on_r));
  host_reader host_reader_i (
    .mclk(mclk), .resetn(resetn), .go(go), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .words(w), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ends any event pulse, lets flags settle, then reads all words
  task snap;
    @(posedge mclk) ev <= '0;
    repeat (3) @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    k = 0;
    while (k < 40 && (busy !== 1'b0 || k == 0)) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 40) chk(16'hdead, 16'h0000);
  endtask : snap

  function logic [31:0] pair_exp(input logic signed [31:0] v);
    logic signed [31:0] q;
    q = v / 32'sd1000;
    if (v % 32'sd1000 < 0) q = q - 32'sd1;
    if (lv.binary_format) return lv.upper_first ? v : {v[15:0], v[31:16]};
    return {q[15:0], 16'(v - q * 32'sd1000)};
  endfunction : pair_exp

  function logic signed [31:0] rnd_pos;
    return $signed(32'($urandom % 65536000)) - 32'sd32768000;
  endfunction : rnd_pos

  initial begin
    #(20 * 8000);
    n_fail++;
    $display("mismatch at %0t: timeout", $time);
    tally_and_finish;
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    resetn = 1'b0;
    go = 1'b0;
    ev = '0;
    lv = '0;
    pins = '0;
    motor_pos = 0;
    encoder_pos = 0;
    captured_pos = 0;
    current_value = 16'h0000;
    jerk_value = 16'h0000;
    gear_num = 16'h0001;
    gear_den = 16'h0001;
    k = $urandom(8492);
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    snap;
    chk(w[0][15:13], 16'h0003);
    chk({w[0][10], w[0][3], cmd_permit_r}, 16'h0006);
    chk({w[1][12], w[1][8]}, 16'h0000);
    chk(w[8], 16'h000a);
    for (i = 10; i < 16; i++) chk(w[i], 16'h0000);
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      motor_pos <= (i == 0) ? -32'sd32768000 : (i == 1) ? 32'sd32767999 :
                   (i == 2) ? -32'sd1 : rnd_pos();
      encoder_pos <= rnd_pos();
      captured_pos <= rnd_pos();
      jerk_value <= 16'($urandom);
      lv.binary_format <= (i > 2) && $urandom % 2;
      lv.upper_first <= 1'($urandom);
      snap;
      for (j = 0; j < 3; j++) begin
        p = (j == 0) ? motor_pos : (j == 1) ? encoder_pos : captured_pos;
        e = pair_exp(p);
        chk(w[2 + 2 * j], e[31:16]);
        chk(w[3 + 2 * j], e[15:0]);
      end
      chk(w[9], jerk_value);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge mclk) begin
        ev.cfg_write <= 1'b1;
        ev.cfg_valid <= (i != 1);
      end
      snap;
      chk({w[0][13], cmd_permit_r}, (i == 1) ? 16'h0002 : 16'h0001);
      chk({w[0][10], abs_move_permit_r}, 16'h0002);
    end
    @(posedge mclk) ev.preset <= 1'b1;
    snap;
    chk({w[0][10], abs_move_permit_r}, 16'h0001);
    @(posedge mclk) ev.homing_done <= 1'b1;
    snap;
    chk({w[0][4], w[0][7], w[0][10]}, 16'h0004);
    @(posedge mclk) ev.cmd_invalid <= 1'b1;
    snap;
    snap;
    chk({w[0][12], w[0][7]}, 16'h0002);
    @(posedge mclk) ev.error_reset <= 1'b1;
    snap;
    chk(w[0][12], 16'h0000);
    @(posedge mclk) {ev.jog_reg_range_err, ev.cmd_invalid} <= 2'h3;
    snap;
    chk({w[0][12], w[0][7]}, 16'h0003);
    @(posedge mclk) {ev.move_cmd, ev.error_reset} <= 2'h3;
    snap;
    chk({w[0][12], w[0][7]}, 16'h0000);
    @(posedge mclk) ev.move_done <= 1'b1;
    snap;
    chk(w[0][7], 16'h0001);
    @(posedge mclk) ev.stop_event <= 1'b1;
    snap;
    chk({w[0][10], w[0][4], abs_move_permit_r}, 16'h0004);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk) begin
        current_value <= cv[i];
        ev.current_write <= 1'b1;
      end
      snap;
      chk(w[8], ce[i]);
      chk({w[0][12], current_accepted_r[14:0]}, ce[i]);
    end
    for (i = 0; i < 6; i++) begin
      r = 7'($urandom);
      @(posedge mclk) {lv.decelerating, lv.accelerating, lv.segment_slot_ready,
                       lv.assy_mode, lv.hold_state, lv.turning_reverse, lv.turning_forward} <= r;
      snap;
      chk(w[0][6:5], {r[6], r[5] & ~r[6]});
      chk(w[0][9:8], r[4:3]);
      chk(w[0][3:0], {~(r[1] | r[0]), r[2:0]});
    end
    for (i = 0; i < 2; i++) begin
      @(posedge mclk) {lv.config_mode, lv.stall_detect_en, lv.internal_fault} <= {3{i[0]}};
      hb0 = 0;
      hb1 = 0;
      for (j = 0; j < 10; j++) begin
        repeat ($urandom % 8) @(posedge mclk);
        snap;
        if (w[1][11] === 1'b1) hb1++;
        else hb0++;
      end
      chk(w[0][15:13], i ? 16'h0005 : 16'h0002);
      chk(i ? (hb1 == 0) : (hb1 > 0 && hb0 > 0), 16'h0001);
    end
    @(posedge mclk) lv <= '0;
    @(posedge mclk) lv.driver_enable_req <= 1'b1;
    @(posedge mclk) pins.estop <= 1'b1;
    snap;
    chk({w[1][15], power_stage_on_r, w[0][11]}, 16'h0007);
    @(posedge mclk) lv.overtemp <= 1'b1;
    snap;
    @(posedge mclk) lv.overtemp <= 1'b0;
    snap;
    chk({w[1][15], w[1][7]}, 16'h0001);
    @(posedge mclk) {ev.fault_clear, ev.error_reset, pins.estop} <= 3'h6;
    snap;
    chk({w[1][7], w[0][11]}, 16'h0000);
    @(posedge mclk) {lv.motor_idle, lv.idle_to_zero, pins.output_one, ev.stall} <= 4'hf;
    snap;
    chk({w[1][15:13], w[0][10]}, 16'h0007);
    @(posedge mclk) {lv.move_active, pins.limit_fwd, lv.gearing_active} <= 3'h7;
    gear_num <= 16'h0000;
    snap;
    chk({w[0][11], w[1][10:9]}, 16'h0007);
    @(posedge mclk) pins.limit_fwd <= 1'b0;
    snap;
    chk(w[1][10], 16'h0000);
    @(posedge mclk) {lv.move_active, pins.limit_rev, ev.error_reset} <= 3'h3;
    snap;
    chk({w[0][11], w[1][10]}, 16'h0000);
    @(posedge mclk) {ev.jog_start, ev.jog_reverse} <= 2'h3;
    snap;
    chk(w[0][11], 16'h0001);
    @(posedge mclk) {ev.error_reset, ev.preset, lv.homing_active, lv.homing_reverse} <= 4'hf;
    snap;
    chk({w[0][11], w[0][10]}, 16'h0000);
    @(posedge mclk) {lv.homing_reverse, ev.net_reconnect, ev.current_write} <= 3'h3;
    current_value <= 16'h0014;
    snap;
    chk({w[0][11], w[0][10]}, 16'h0003);
    chk(w[8], 16'h0014);
    // second reset in mid-run
    @(posedge mclk) begin
      lv <= '0;
      pins <= '0;
      resetn <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    snap;
    chk({w[0][13:10], w[0][7], w[0][4]}, 16'h0024);
    chk({w[1][15:12], w[1][10:0]}, 16'h0000);
    chk({cmd_permit_r, abs_move_permit_r, power_stage_on_r}, 16'h0000);
    chk(current_accepted_r, 16'h000a);
    tally_and_finish;
  end
endmodule : testbench
